// ===== hdl/pcb_bank.v
// port, comparator and power configuration register bank with timer0 clock mux
//
// Overview of operation
// - timer0 source select 0 takes the instruction cycle clock regardless of low osc select.
// - source 1 with low osc select 0 counts transitions on the external count pin.
// - source 1 with low osc select 1 counts the low-frequency oscillator instead.
// - edge select applies equally to the oscillator source and the pin source.
// - edge select 1 counts falling transitions, 0 counts rising transitions.
// - port A direction bits: 1 makes the pin an input, 0 an output.
// - port B direction bits 0-5 likewise; bits 7 and 6 unimplemented.
// - active-low pull-up enables for port A pins 0-4, 6 and 7.
// - bit 5 of port A pull control is an active-low pull-down enable.
// - prescaler0 count register reads the live counter, read-only.
// - port B open-drain bits: 1 open-drain, 0 push-pull; reset to 0.
// - comparator is pad-pair mode when reference select is zero, else pad-ref mode.
// - reference select n routes n sixteenths of supply to the inverting input.
// - pad-ref mode pad select picks non-inverting pad, code 0101 gives ground.
// - pad-pair mode pad select picks both inputs from sixteen pad pairs.
// - three-bit detector level select, reset 111.
// - bit 6 of power control one shows detector output; writes ignored.
// - global irq enable 1 allows enabled interrupts, 0 blocks all; reset 0.
// - global irq enable set and cleared by instructions, readable by io read.
// - power control bits 5 and 1 are plain storage, reset 0.
`timescale 1ns/10ps
`include "pcb_defines.vh"

module pcb_bank
(
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  ps0_count,
  lvd_in,
  enable_irq_instr,
  disable_irq_instr,
  irq_req,
  instr_cycle_clock,
  external_count_input,
  low_osc_in,
  port_a_dir,
  port_b_dir,
  port_a_pullup_n,
  pin5_pulldown_n,
  port_b_od,
  cmp_pad_pair_mode,
  cmp_ref_level,
  cmp_pos_sel,
  cmp_neg_sel,
  lvd_level_select,
  timer0_run,
  timer0_tick,
  irq_out
);
  input  wire        hclk;
  input  wire        hresetn;
  input  wire        hsel;
  input  wire [31:0] haddr;
  input  wire [1:0]  htrans;
  input  wire        hwrite;
  input  wire [2:0]  hsize;
  input  wire [31:0] hwdata;
  input  wire        hready;
  output reg  [31:0] hrdata;
  output reg         hreadyout;
  output reg         hresp;
  input  wire [7:0]  ps0_count;
  input  wire        lvd_in;
  input  wire        enable_irq_instr;
  input  wire        disable_irq_instr;
  input  wire        irq_req;
  input  wire        instr_cycle_clock;
  input  wire        external_count_input;
  input  wire        low_osc_in;
  output reg  [7:0]  port_a_dir;
  output reg  [5:0]  port_b_dir;
  output reg  [7:0]  port_a_pullup_n;
  output reg         pin5_pulldown_n;
  output reg  [5:0]  port_b_od;
  output reg         cmp_pad_pair_mode;
  output reg  [3:0]  cmp_ref_level;
  output reg  [3:0]  cmp_pos_sel;
  output reg  [3:0]  cmp_neg_sel;
  output reg  [2:0]  lvd_level_select;
  output reg         timer0_run;
  output reg         timer0_tick;
  output reg         irq_out;

  // ------------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------------
  reg  [2:0] sync1_r;
  reg  [2:0] sync2_r;
  reg        ext_prev_r;
  reg        inst_prev_r;
  reg        lvd_flag_r;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_r     <= 3'h0;
      sync2_r     <= 3'h0;
      lvd_flag_r  <= 1'b0;
    end
    else
    begin
      sync1_r     <= {lvd_in, low_osc_in, external_count_input};
      sync2_r     <= sync1_r;
      lvd_flag_r  <= sync2_r[2];
    end
  end

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg  [7:0] pa_dir_r;
  reg  [5:0] pb_dir_r;
  reg  [7:0] pa_pull_r;
  reg  [5:0] pb_od_r;
  reg  [7:0] cmp_sel_r;
  reg        gie_r;
  reg        gp_high_r;
  reg  [2:0] lvd_lvl_r;
  reg        gp_low_r;
  reg        t0_run_r;
  reg  [7:0] t0_mode_r;

  // address phase capture
  reg         wr_pend_r;
  reg  [3:0]  wr_idx_r;
  reg  [31:0] rd_nxt;
  wire        take;
  wire        rd_take;
  wire [3:0]  a_idx;
  wire        a_ok;

  assign take    = hsel & htrans[1] & hready;
  assign rd_take = take & ~hwrite;
  assign a_idx   = haddr[5:2];
  assign a_ok    = (haddr[31:6] == 26'h0);

  // external-type source: pin or low oscillator
  wire sel_src;
  assign sel_src = t0_mode_r[`PCB_BIT_T0_LOWOSC] ? sync2_r[1] : sync2_r[0];

  // ------------------------------------------------------------------
  // bus address phase and response
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      wr_idx_r  <= 4'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_r <= take & hwrite & a_ok;
      wr_idx_r  <= a_idx;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // global interrupt enable
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      gie_r <= 1'b0;
    else if (enable_irq_instr)
      gie_r <= 1'b1;
    else if (disable_irq_instr)
      gie_r <= 1'b0;
    else if (wr_pend_r && (wr_idx_r == `PCB_IDX_POWER_CONTROL_ONE))
      gie_r <= hwdata[`PCB_BIT_GIE];
  end

  // ------------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pa_dir_r  <= `PCB_RST_PA_DIR;
      pb_dir_r  <= `PCB_RST_PB_DIR;
      pa_pull_r <= `PCB_RST_PA_PULL;
      pb_od_r   <= `PCB_RST_PB_OD;
      cmp_sel_r <= `PCB_RST_CMP_SEL;
      gp_high_r <= 1'b0;
      lvd_lvl_r <= `PCB_RST_LVD_LEVEL;
      gp_low_r  <= 1'b0;
      t0_run_r  <= `PCB_RST_T0_RUN;
      t0_mode_r <= `PCB_RST_T0_MODE;
    end
    else if (wr_pend_r)
    begin
      case (wr_idx_r)
        `PCB_IDX_PA_DIR:  pa_dir_r  <= hwdata[7:0];
        `PCB_IDX_PB_DIR:  pb_dir_r  <= hwdata[5:0];
        `PCB_IDX_PA_PULL: pa_pull_r <= hwdata[7:0];
        `PCB_IDX_PB_OD:   pb_od_r   <= hwdata[5:0];
        `PCB_IDX_CMP_SEL: cmp_sel_r <= hwdata[7:0];
        `PCB_IDX_T0_MODE: t0_mode_r <= hwdata[7:0];
        `PCB_IDX_POWER_CONTROL_ONE:
        begin
          gp_high_r <= hwdata[`PCB_BIT_GP_HIGH];
          lvd_lvl_r <= hwdata[`PCB_BIT_LVL_HI:`PCB_BIT_LVL_LO];
          gp_low_r  <= hwdata[`PCB_BIT_GP_LOW];
          t0_run_r  <= hwdata[`PCB_BIT_T0_RUN];
        end
        default:          t0_run_r  <= t0_run_r;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  always @*
  begin
    rd_nxt = 32'h0;
    if (a_ok)
    begin
      case (a_idx)
        `PCB_IDX_PA_DIR:  rd_nxt = {24'h0, pa_dir_r};
        `PCB_IDX_PB_DIR:  rd_nxt = {26'h0, pb_dir_r};
        `PCB_IDX_PA_PULL: rd_nxt = {24'h0, pa_pull_r};
        `PCB_IDX_PS0_CNT: rd_nxt = {24'h0, ps0_count};
        `PCB_IDX_PB_OD:   rd_nxt = {26'h0, pb_od_r};
        `PCB_IDX_CMP_SEL: rd_nxt = {24'h0, cmp_sel_r};
        `PCB_IDX_T0_MODE: rd_nxt = {24'h0, t0_mode_r};
        `PCB_IDX_CMP_ROUTE:
          rd_nxt = {20'h0, cmp_pos_sel, cmp_neg_sel, 3'h0, cmp_pad_pair_mode};
        `PCB_IDX_POWER_CONTROL_ONE:
          rd_nxt = {24'h0, gie_r, lvd_flag_r, gp_high_r, lvd_lvl_r, gp_low_r,
                    t0_run_r};
        default:          rd_nxt = 32'h0;
      endcase
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0;
    else if (rd_take)
      hrdata <= rd_nxt;
  end

  // ------------------------------------------------------------------
  // comparator routing
  // ------------------------------------------------------------------
  reg  [3:0] pos_nxt;
  reg  [3:0] neg_nxt;
  wire       pair_mode;
  assign pair_mode = (cmp_sel_r[3:0] == 4'h0);

  always @*
  begin
    pos_nxt = `PCB_CMP_GND;
    neg_nxt = `PCB_CMP_REF;
    if (!pair_mode)
    begin
      case (cmp_sel_r[7:4])
        4'h5:    pos_nxt = `PCB_CMP_GND;
        4'hE:    pos_nxt = `PCB_CMP_GND;
        4'hF:    pos_nxt = `PCB_CMP_GND;
        default: pos_nxt = cmp_sel_r[7:4];
      endcase
    end
    else
    begin
      case (cmp_sel_r[7:4])
        4'h0:    begin pos_nxt = 4'h0; neg_nxt = 4'h1; end
        4'h1:    begin pos_nxt = 4'h1; neg_nxt = 4'h0; end
        4'h2:    begin pos_nxt = 4'h2; neg_nxt = 4'h3; end
        4'h3:    begin pos_nxt = 4'h3; neg_nxt = 4'h2; end
        4'h4:    begin pos_nxt = 4'h0; neg_nxt = 4'hB; end
        4'h5:    begin pos_nxt = 4'h1; neg_nxt = 4'hA; end
        4'h6:    begin pos_nxt = 4'h2; neg_nxt = 4'hD; end
        4'h7:    begin pos_nxt = 4'h3; neg_nxt = 4'hC; end
        4'h8:    begin pos_nxt = 4'hA; neg_nxt = 4'h1; end
        4'h9:    begin pos_nxt = 4'hB; neg_nxt = 4'h0; end
        4'hA:    begin pos_nxt = 4'hC; neg_nxt = 4'h3; end
        4'hB:    begin pos_nxt = 4'hD; neg_nxt = 4'h2; end
        4'hC:    begin pos_nxt = 4'hA; neg_nxt = 4'hB; end
        4'hD:    begin pos_nxt = 4'hB; neg_nxt = 4'hA; end
        4'hE:    begin pos_nxt = 4'hC; neg_nxt = 4'hD; end
        default: begin pos_nxt = 4'hD; neg_nxt = 4'hC; end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // timer0 clock mux and output registers
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ext_prev_r  <= 1'b0;
      inst_prev_r <= 1'b0;
    end
    else
    begin
      ext_prev_r  <= sel_src;
      inst_prev_r <= instr_cycle_clock;
    end
  end

  reg tick_nxt;
  always @*
  begin
    if (!t0_mode_r[`PCB_BIT_T0_SRC])
      tick_nxt = instr_cycle_clock & ~inst_prev_r;
    else if (t0_mode_r[`PCB_BIT_T0_EDGE])
      tick_nxt = ~sel_src & ext_prev_r;
    else
      tick_nxt = sel_src & ~ext_prev_r;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      port_a_dir        <= `PCB_RST_PA_DIR;
      port_b_dir        <= `PCB_RST_PB_DIR;
      port_a_pullup_n   <= `PCB_RST_PA_PULL;
      pin5_pulldown_n   <= 1'b1;
      port_b_od         <= `PCB_RST_PB_OD;
    end
    else
    begin
      port_a_dir        <= pa_dir_r;
      port_b_dir        <= pb_dir_r;
      port_a_pullup_n   <= {pa_pull_r[7:6], 1'b1, pa_pull_r[4:0]};
      pin5_pulldown_n   <= pa_pull_r[5];
      port_b_od         <= pb_od_r;
    end
  end

  // ------------------------------------------------------------------
  // comparator, detector, timer and interrupt outputs
  // ------------------------------------------------------------------
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmp_pad_pair_mode <= 1'b1;
      cmp_ref_level     <= 4'h0;
      cmp_pos_sel       <= 4'h0;
      cmp_neg_sel       <= 4'h1;
      lvd_level_select  <= `PCB_RST_LVD_LEVEL;
      timer0_run        <= `PCB_RST_T0_RUN;
      timer0_tick       <= 1'b0;
      irq_out           <= 1'b0;
    end
    else
    begin
      cmp_pad_pair_mode <= pair_mode;
      cmp_ref_level     <= cmp_sel_r[3:0];
      cmp_pos_sel       <= pos_nxt;
      cmp_neg_sel       <= neg_nxt;
      lvd_level_select  <= lvd_lvl_r;
      timer0_run        <= t0_run_r;
      timer0_tick       <= tick_nxt;
      irq_out           <= irq_req & gie_r;
    end
  end
endmodule // pcb_bank

// ===== hdl/pcb_defines.vh
// register offsets, reset values and field positions of the port and power configuration bank
`ifndef PCB_DEFINES_VH
`define PCB_DEFINES_VH
// byte addresses are four times the register index
`define PCB_IDX_PA_DIR      4'h5
`define PCB_IDX_PB_DIR      4'h6
`define PCB_IDX_PA_PULL     4'h9
`define PCB_IDX_PS0_CNT     4'hA
`define PCB_IDX_PB_OD       4'hC
`define PCB_IDX_CMP_SEL     4'hE
`define PCB_IDX_POWER_CONTROL_ONE       4'hF
`define PCB_IDX_T0_MODE     4'h0
`define PCB_IDX_CMP_ROUTE   4'h1
`define PCB_RST_PA_DIR      8'hFF
`define PCB_RST_PB_DIR      6'h3F
`define PCB_RST_PA_PULL     8'hFF
`define PCB_RST_PB_OD       6'h00
`define PCB_RST_CMP_SEL     8'h00
`define PCB_RST_LVD_LEVEL   3'h7
`define PCB_RST_T0_RUN      1'b1
`define PCB_RST_T0_MODE     8'h30
`define PCB_BIT_GIE         7
`define PCB_BIT_LVD         6
`define PCB_BIT_GP_HIGH     5
`define PCB_BIT_GP_LOW      1
`define PCB_BIT_LVL_HI      4
`define PCB_BIT_LVL_LO      2
`define PCB_BIT_T0_RUN      0
`define PCB_BIT_T0_LOWOSC   7
`define PCB_BIT_T0_SRC      5
`define PCB_BIT_T0_EDGE     4
// comparator input codes: 0-7 port A pin, 8-13 port B pin 0-5, 14 ground, 15 reference
`define PCB_CMP_GND         4'hE
`define PCB_CMP_REF         4'hF
`endif

// ===== test/pcb_bank_props.sv
// assertion checker for the port and power configuration bank
`timescale 1ns/10ps
module pcb_bank_props
(
  input wire        hclk,
  input wire        hresetn,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire [7:0]  ps0_count,
  input wire        enable_irq_instr,
  input wire        disable_irq_instr,
  input wire        irq_req,
  input wire        irq_out,
  input wire [7:0]  port_a_dir,
  input wire        cmp_pad_pair_mode,
  input wire [3:0]  cmp_ref_level,
  input wire [3:0]  cmp_pos_sel,
  input wire [3:0]  cmp_neg_sel,
  input wire        timer0_tick
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && htrans[1] && hready;
  property p_irq_on; enable_irq_instr && !disable_irq_instr ##1 irq_req |=> irq_out; endproperty
  property p_irq_off; disable_irq_instr && !enable_irq_instr |=> ##1 !irq_out; endproperty
  property p_mode; cmp_pad_pair_mode == (cmp_ref_level == 4'h0); endproperty
  property p_ref_neg; !cmp_pad_pair_mode |-> cmp_neg_sel == 4'hF; endproperty
  property p_ref_pos; !cmp_pad_pair_mode |-> cmp_pos_sel != 4'h5 && cmp_pos_sel != 4'hF; endproperty
  property p_ps0;
    take && !hwrite && haddr == 32'h28 |=> hrdata == {24'h0, $past(ps0_count)};
  endproperty
  property p_dir; !$stable(port_a_dir) |-> $past(take && hwrite, 3); endproperty
  property p_tick; timer0_tick |=> !timer0_tick; endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq not passed");
  a_irq_off: assert property (p_irq_off) else $error("irq not blocked");
  a_mode: assert property (p_mode) else $error("bad comparator mode");
  a_ref_neg: assert property (p_ref_neg) else $error("bad inverting input");
  a_ref_pos: assert property (p_ref_pos) else $error("bad pad input");
  a_ps0: assert property (p_ps0) else $error("bad count readback");
  a_dir: assert property (p_dir) else $error("direction changed unasked");
  a_tick: assert property (p_tick) else $error("tick too long");
  c_irq: cover property (enable_irq_instr ##2 irq_out);
  c_tick: cover property (timer0_tick);
  c_ref: cover property (!cmp_pad_pair_mode);
endmodule // pcb_bank_props

bind pcb_bank pcb_bank_props pcb_bank_props_inst (.*);

// ===== test/tb_top.sv
// self-checking bench for the port and power configuration bank
`timescale 1ns/10ps
module tb_top;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  ps0_count = 8'h0;
  logic        lvd_in = 1'b0;
  logic        enable_irq_instr = 1'b0;
  logic        disable_irq_instr = 1'b0;
  logic        irq_req = 1'b0;
  logic        instr_cycle_clock = 1'b0;
  logic        external_count_input = 1'b0;
  logic        low_osc_in = 1'b0;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire  [7:0]  port_a_dir, port_a_pullup_n;
  wire  [5:0]  port_b_dir, port_b_od;
  wire  [3:0]  cmp_ref_level, cmp_pos_sel, cmp_neg_sel;
  wire  [2:0]  lvd_level_select;
  wire         pin5_pulldown_n, cmp_pad_pair_mode, timer0_run, timer0_tick, irq_out;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          k;
  int          rw [6] = '{5, 6, 9, 12, 14, 15};
  logic [31:0] rv;
  logic [7:0]  m [16];
  logic [7:0]  cr, cf;
  localparam logic [127:0] pair_tab = 128'h01102332_0B1A2D3C_A1B0C3D2_ABBACDDC;

  pcb_bank pcb_bank_inst (.hsize(3'h2), .hready(hreadyout), .hresp(hresp), .*);
  always #50 hclk = ~hclk;

  // ----------
  // model and bus tasks
  // ----------
  function automatic logic [7:0] mk(input int i);
    case (i)
      5, 9, 14: return 8'hFF;
      6, 12:    return 8'h3F;
      15:       return 8'hBF;
      default:  return 8'h00;
    endcase
  endfunction

  function automatic logic [12:0] cmpx(input logic [7:0] r);
    if (r[3:0] == 4'h0)
      return {1'b1, 4'h0, pair_tab[127 - 8 * r[7:4] -: 8]};
    return {1'b0, r[3:0], (r[7:4] == 4'h5 || r[7:4] > 4'hD) ? 4'hE : r[7:4], 4'hF};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 50)
    begin
      @(posedge hclk);
      n++;
    end
    if (n == 50)
    begin
      error_cnt++;
      end_of_test;
    end
  endtask

  task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rv = hrdata;
  endtask

  task automatic rreg(input int i);
    xfer(32'(4 * i), 1'b0, 32'h0);
    chk(rv, {24'h0, m[i]});
  endtask

  task automatic wreg(input int i, input logic [7:0] d);
    xfer(32'(4 * i), 1'b1, {24'h0, d});
    m[i] = (d & mk(i)) | (m[i] & ~mk(i));
    rreg(i);
  endtask

  task automatic pchk;
    chk({port_a_dir, port_a_pullup_n, port_b_dir, port_b_od, timer0_run, lvd_level_select},
        {m[5], m[9] | 8'h20, m[6][5:0], m[12][5:0], m[15][0], m[15][4:2]});
    chk({pin5_pulldown_n, cmp_pad_pair_mode, cmp_ref_level, cmp_pos_sel, cmp_neg_sel,
         hresp, hreadyout},
        {m[9][5], cmpx(m[14]), 1'b0, 1'b1});
  endtask

  task automatic cnt(input int s, input logic v, output logic [7:0] c);
    c = 8'h0;
    {low_osc_in, external_count_input, instr_cycle_clock} <= v ? 3'(1 << s) : 3'h0;
    repeat (8)
    begin
      @(posedge hclk);
      #1 c = c + timer0_tick;
    end
  endtask

  // ----------
  // tests
  // ----------
  initial
  begin
    void'($urandom(32'h383A));
    m = '{8'h30, 0, 0, 0, 0, 8'hFF, 8'h3F, 0, 0, 8'hFF, 0, 0, 0, 0, 0, 8'h1D};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 16; i++)
      if (i != 1 && i != 10)
        rreg(i);
    pchk;
    $display("test reset done");
    repeat (30)
    begin
      wreg(rw[$urandom % 6], 8'($urandom));
      pchk;
    end
    for (int i = 0; i < 32; i++)
    begin
      wreg(14, {4'(i), i[4] ? 4'(1 + $urandom % 15) : 4'h0});
      pchk;
    end
    k = $urandom;
    ps0_count <= 8'(k);
    m[10] = 8'(k);
    wreg(10, ~m[10]);
    lvd_in <= 1'b1;
    repeat (5) @(posedge hclk);
    m[15][6] = 1'b1;
    wreg(15, m[15] & 8'hBF);
    $display("test registers done");
    irq_req <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      {disable_irq_instr, enable_irq_instr} <= i ? 2'h2 : 2'h1;
      @(posedge hclk);
      {disable_irq_instr, enable_irq_instr} <= 2'h0;
      repeat (3) @(posedge hclk);
      m[15][7] = !i;
      rreg(15);
      chk(irq_out, !i);
    end
    irq_req <= 1'b0;
    $display("test irq done");
    wreg(9, m[9] | 8'hC0);
    for (int md = 0; md < 8; md++)
      for (int s = 0; s < 3; s++)
      begin
        xfer(32'h0, 1'b1, {24'h0, md[2], 1'b0, md[1], md[0], 4'h0});
        repeat (2) @(posedge hclk);
        cnt(s, 1'b1, cr);
        cnt(s, 1'b0, cf);
        k = md[1] ? (md[2] ? 2 : 1) : 0;
        chk({cr, cf}, {7'h0, k == s && (s == 0 || !md[0]),
                       7'h0, k == s && s != 0 && md[0]});
      end
    $display("test timer done");
    end_of_test;
  end
endmodule // tb_top
